/* rtl/card_exec.sv */
// command executor of a flash card task-file interface, APB register slave
// assumes: host data pins, ack and strobe are asynchronous; verify_error same clock
`include "card_exec_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module card_exec
   import card_exec_pkg::*;
#(
   parameter int          IDLE_CYCLES   = `IDLE_CYCLES,
   parameter int          VERIFY_CYCLES = 4,
   parameter logic [7:0]  MAX_BLOCK     = 8'h10,
   parameter logic [7:0]  TRACK_SECT    = 8'h3f,
   parameter logic [3:0]  LAST_HEAD     = 4'hf
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] host_data_in,
   input  wire logic        dma_acknowledge_n,
   input  wire logic        io_write_strobe_n,
   input  wire logic        verify_error,
   output logic             dma_request,
   output logic             host_interrupt,
   output logic             sleep_mode,
   output logic             buf_wr_en,
   output logic      [7:0]  buf_wr_addr,
   output logic      [15:0] buf_wr_data
);
   exec_state_t state_reg;
   logic [7:0]  feat_reg, count_reg, secnum_reg, cyl_lo_reg, cyl_hi_reg, head_reg;
   logic [7:0]  cmd_reg, err_reg, block_reg, mode_reg, word_reg;
   logic        busy_reg, drq_reg, errf_reg, intrq_reg, sleep_reg;
   logic        keep_reg, eightbit_reg, wcache_reg, lookahead_reg, soft_rst_reg;
   logic [31:0] idle_reg, vcnt_reg;
   logic [15:0] data_s1, data_s2;
   logic        ack_s1, ack_s2;
   logic [2:0]  strb_s;
   logic        apb_wr, apb_rd, mapped, cmd_wr, tf_wr;
   logic [3:0]  idx;
   logic        abort_cmd, finish_now, feat_valid, mode_ok, blk_ok;
   logic        pio_acc, dma_acc, sect_end, last_sect, adv_addr, done_ok, done_err;
   logic        vfy_tick;
   logic [27:0] lba;

   assign idx     = paddr[5:2];
   assign mapped  = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0) && (idx <= `IDX_CONTROL);
   assign apb_wr  = psel && penable && pwrite && mapped;
   assign apb_rd  = psel && penable && !pwrite && mapped;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   // task file is frozen while a command runs so the host cannot corrupt it
   assign tf_wr   = apb_wr && (state_reg == st_idle) && !soft_rst_reg;
   assign cmd_wr  = tf_wr && (idx == `IDX_COMMAND);

   assign lba = {head_reg[3:0], cyl_hi_reg, cyl_lo_reg, secnum_reg};
   assign last_sect = (count_reg == 8'h01);

   // pins pass two flops; strobe gets a third stage for the edge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         data_s1 <= 16'h0000;
         data_s2 <= 16'h0000;
         ack_s1  <= 1'b1;
         ack_s2  <= 1'b1;
         strb_s  <= 3'h7;
      end else begin
         data_s1 <= host_data_in;
         data_s2 <= data_s1;
         ack_s1  <= dma_acknowledge_n;
         ack_s2  <= ack_s1;
         strb_s  <= {strb_s[1:0], io_write_strobe_n};
      end
   end

   // a word is taken at the trailing edge of the strobe, data then settled
   assign dma_acc = (state_reg == st_dma_xfer) && !ack_s2 && strb_s[1] && !strb_s[2];
   assign pio_acc = (state_reg == st_pio_wr) && apb_wr && (idx == `IDX_DATA);
   assign sect_end = (pio_acc || dma_acc) && (word_reg == `LAST_WORD);
   assign vfy_tick = (state_reg == st_verify) && (vcnt_reg == 32'(VERIFY_CYCLES - 1));

   always_comb begin
      unique case (feat_reg[7:0])
         `SUB_XFER_MODE: feat_valid = mode_ok;
         `SUB_NO_LOOKAH, `SUB_WC_ON, `SUB_WC_OFF,
         `SUB_KEEP, `SUB_REVERT, `SUB_8BIT_ON, `SUB_8BIT_OFF: feat_valid = 1'b1;
         default:        feat_valid = 1'b0;
      endcase
   end
   // only default pio, flow-control pio and multiword dma mode classes
   assign mode_ok = (count_reg[7:3] == 5'h00) || (count_reg[7:3] == 5'h01)
                 || (count_reg[7:3] == 5'h04);
   assign blk_ok  = (count_reg <= MAX_BLOCK) && ((count_reg & (count_reg - 8'h01)) == 8'h00);

   always_comb begin
      abort_cmd  = 1'b0;
      finish_now = 1'b0;
      if (state_reg == st_exec) begin
         case (cmd_reg)
            `CMD_VERIFY0, `CMD_VERIFY1, `CMD_WRBUF: finish_now = 1'b0;
            `CMD_FEATURE: begin
               finish_now = 1'b1;
               abort_cmd  = !feat_valid;
            end
            `CMD_SETMULT: begin
               finish_now = 1'b1;
               abort_cmd  = (count_reg != 8'h00) && !blk_ok;
            end
            `CMD_SLEEP0, `CMD_SLEEP1, `CMD_STBY0, `CMD_STBY1,
            `CMD_STBYI0, `CMD_STBYI1: finish_now = 1'b1;
            `CMD_DMAWR: begin
               finish_now = eightbit_reg;
               abort_cmd  = eightbit_reg;
            end
            default: begin
               finish_now = 1'b1;
               abort_cmd  = 1'b1;
            end
         endcase
      end
   end

   assign done_err = abort_cmd || (vfy_tick && verify_error);
   assign done_ok  = (finish_now && !abort_cmd)
                  || (vfy_tick && !verify_error && last_sect)
                  || (sect_end && (last_sect || pio_acc));
   // address moves on only when another sector follows, so the last stays put;
   // buffer write is one sector whatever the count holds, so it never walks
   assign adv_addr = ((vfy_tick && !verify_error) || (sect_end && dma_acc)) && !last_sect;

   // execution sequencer
   always_ff @(posedge clk_sys) begin
      if (srst || soft_rst_reg) begin
         state_reg <= st_idle;
         cmd_reg   <= 8'h00;
         vcnt_reg  <= 32'h0;
         word_reg  <= 8'h00;
      end else begin
         unique case (state_reg)
            st_idle: begin
               if (cmd_wr) begin
                  cmd_reg   <= pwdata[7:0];
                  state_reg <= st_exec;
               end
            end
            st_exec: begin
               vcnt_reg <= 32'h0;
               word_reg <= 8'h00;
               if (finish_now)
                  state_reg <= st_idle;
               else if (cmd_reg == `CMD_VERIFY0 || cmd_reg == `CMD_VERIFY1)
                  state_reg <= st_verify;
               else if (cmd_reg == `CMD_WRBUF)
                  state_reg <= st_pio_wr;
               else
                  state_reg <= st_dma_start;
            end
            st_verify: begin
               vcnt_reg <= vfy_tick ? 32'h0 : vcnt_reg + 32'h1;
               if (vfy_tick && (verify_error || last_sect))
                  state_reg <= st_idle;
            end
            st_pio_wr: begin
               if (pio_acc)
                  word_reg <= word_reg + 8'h01;
               if (sect_end)
                  state_reg <= st_idle;
            end
            st_dma_start: state_reg <= st_dma_xfer;
            st_dma_xfer: begin
               if (dma_acc)
                  word_reg <= word_reg + 8'h01;
               if (sect_end && last_sect)
                  state_reg <= st_idle;
            end
         endcase
      end
   end

   // status flags seen by the host
   always_ff @(posedge clk_sys) begin
      if (srst || soft_rst_reg) begin
         busy_reg  <= 1'b0;
         drq_reg   <= 1'b0;
         errf_reg  <= 1'b0;
         intrq_reg <= 1'b0;
         err_reg   <= 8'h00;
      end else begin
         if (cmd_wr) begin
            busy_reg  <= 1'b1;
            errf_reg  <= 1'b0;
            err_reg   <= 8'h00;
            intrq_reg <= 1'b0;
         end else if (done_err) begin
            busy_reg  <= 1'b0;
            drq_reg   <= 1'b0;
            errf_reg  <= 1'b1;
            intrq_reg <= 1'b1;
            err_reg[`ER_ABRT_BIT] <= abort_cmd;
            err_reg[`ER_UNC_BIT]  <= !abort_cmd;
         end else if (done_ok) begin
            busy_reg  <= 1'b0;
            drq_reg   <= 1'b0;
            intrq_reg <= 1'b1;
         end else if ((state_reg == st_exec && cmd_reg == `CMD_WRBUF)
                      || state_reg == st_dma_start) begin
            busy_reg <= 1'b0;
            drq_reg  <= 1'b1;
         end else if (apb_rd && idx == `IDX_COMMAND) begin
            intrq_reg <= 1'b0;
         end
      end
   end

   // dma request stands for the whole time words can be taken
   always_ff @(posedge clk_sys) begin
      if (srst || soft_rst_reg)
         dma_request <= 1'b0;
      else if (state_reg == st_dma_start)
         dma_request <= 1'b1;
      else if (sect_end && last_sect)
         dma_request <= 1'b0;
   end

   // sector buffer write port, shared by buffer write and dma write
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         buf_wr_en   <= 1'b0;
         buf_wr_addr <= 8'h00;
         buf_wr_data <= 16'h0000;
      end else begin
         buf_wr_en <= pio_acc || dma_acc;
         if (pio_acc || dma_acc) begin
            buf_wr_addr <= word_reg;
            buf_wr_data <= pio_acc ? pwdata[15:0] : data_s2;
         end
      end
   end

   // task file: host writes while idle, sequencer walks address and count
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         feat_reg   <= 8'h00;
         count_reg  <= 8'h01;
         secnum_reg <= 8'h01;
         cyl_lo_reg <= 8'h00;
         cyl_hi_reg <= 8'h00;
         head_reg   <= 8'h00;
      end else if (tf_wr) begin
         case (idx)
            `IDX_FEATURE: feat_reg   <= pwdata[7:0];
            `IDX_COUNT:   count_reg  <= pwdata[7:0];
            `IDX_SECNUM:  secnum_reg <= pwdata[7:0];
            `IDX_CYL_LO:  cyl_lo_reg <= pwdata[7:0];
            `IDX_CYL_HI:  cyl_hi_reg <= pwdata[7:0];
            `IDX_HEAD:    head_reg   <= pwdata[7:0];
            default:      feat_reg   <= feat_reg;
         endcase
      end else if (adv_addr) begin
         count_reg <= count_reg - 8'h01;
         if (head_reg[`HD_LBA_BIT]) begin
            {head_reg[3:0], cyl_hi_reg, cyl_lo_reg, secnum_reg} <= lba + 28'h1;
         end else if (secnum_reg != TRACK_SECT) begin
            secnum_reg <= secnum_reg + 8'h01;
         end else begin
            secnum_reg <= 8'h01;
            if (head_reg[3:0] != LAST_HEAD) begin
               head_reg[3:0] <= head_reg[3:0] + 4'h1;
            end else begin
               head_reg[3:0] <= 4'h0;
               {cyl_hi_reg, cyl_lo_reg} <= {cyl_hi_reg, cyl_lo_reg} + 16'h0001;
            end
         end
      end else if (vfy_tick && !verify_error && last_sect) begin
         count_reg <= 8'h00;
      end
   end

   // feature settings; keep flag survives soft reset, as does what it guards
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         block_reg     <= 8'h00;
         keep_reg      <= 1'b0;
         eightbit_reg  <= 1'b0;
         wcache_reg    <= 1'b0;
         lookahead_reg <= 1'b1;
         mode_reg      <= 8'h00;
      end else if (soft_rst_reg) begin
         if (!keep_reg)
            block_reg <= 8'h00;
      end else if (state_reg == st_exec && !abort_cmd) begin
         if (cmd_reg == `CMD_SETMULT)
            block_reg <= count_reg;
         if (cmd_reg == `CMD_FEATURE) begin
            case (feat_reg)
               `SUB_XFER_MODE: mode_reg      <= count_reg;
               `SUB_NO_LOOKAH: lookahead_reg <= 1'b0;
               `SUB_WC_ON:     wcache_reg    <= 1'b1;
               `SUB_WC_OFF:    wcache_reg    <= 1'b0;
               `SUB_KEEP:      keep_reg      <= 1'b1;
               `SUB_REVERT:    keep_reg      <= 1'b0;
               `SUB_8BIT_ON:   eightbit_reg  <= 1'b1;
               `SUB_8BIT_OFF:  eightbit_reg  <= 1'b0;
               default:        keep_reg      <= keep_reg;
            endcase
         end
      end
   end

   // soft reset bit holds the engine in reset until software clears it
   always_ff @(posedge clk_sys) begin
      if (srst)
         soft_rst_reg <= 1'b0;
      else if (apb_wr && idx == `IDX_CONTROL)
         soft_rst_reg <= pwdata[`CTL_SRST_BIT];
   end

   // power saving: commands wake, idle timer and sleep-class commands doze
   always_ff @(posedge clk_sys) begin
      if (srst || soft_rst_reg) begin
         sleep_reg <= 1'b0;
         idle_reg  <= 32'h0;
      end else if (cmd_wr || state_reg != st_idle) begin
         idle_reg <= 32'h0;
         if (cmd_wr)
            sleep_reg <= 1'b0;
         else if (state_reg == st_exec && !abort_cmd
                  && (cmd_reg == `CMD_SLEEP0 || cmd_reg == `CMD_SLEEP1
                      || cmd_reg == `CMD_STBY0 || cmd_reg == `CMD_STBY1
                      || cmd_reg == `CMD_STBYI0 || cmd_reg == `CMD_STBYI1))
            sleep_reg <= 1'b1;
      end else if (!sleep_reg) begin
         if (idle_reg == 32'(IDLE_CYCLES - 1)) begin
            sleep_reg <= 1'b1;
            idle_reg  <= 32'h0;
         end else begin
            idle_reg <= idle_reg + 32'h1;
         end
      end
   end

   // read data registered in the setup cycle, valid in the access cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         case (mapped ? idx : 4'hf)
            `IDX_FEATURE: prdata <= {24'h0, err_reg};
            `IDX_COUNT:   prdata <= {24'h0, count_reg};
            `IDX_SECNUM:  prdata <= {24'h0, secnum_reg};
            `IDX_CYL_LO:  prdata <= {24'h0, cyl_lo_reg};
            `IDX_CYL_HI:  prdata <= {24'h0, cyl_hi_reg};
            `IDX_HEAD:    prdata <= {24'h0, head_reg};
            `IDX_COMMAND: prdata <= {24'h0, busy_reg, !busy_reg, 2'h0,
                                     drq_reg, 2'h0, errf_reg};
            `IDX_CONTROL: prdata <= {block_reg, mode_reg, 8'h0, 2'h0, keep_reg,
                                     eightbit_reg, wcache_reg, soft_rst_reg,
                                     lookahead_reg, sleep_reg};
            default:      prdata <= 32'h0;
         endcase
      end
   end

   assign host_interrupt = intrq_reg;
   assign sleep_mode     = sleep_reg;
endmodule
`default_nettype wire

/* rtl/card_exec_defs.svh */
// constants for the card command executor: register indices, codes, fields, timing
// assumes a 125 MHz system clock and APB word addressing (byte address = index * 4)
//
// Overview of operation
// - read verify sets busy, never data request
// - verify done clears busy, raises interrupt
// - verify success leaves last sector address
// - verify error keeps failing address, remaining count
// - feature command aborts unsupported subcommand/value
// - eight listed feature subcommands are accepted
// - block-count setup sets busy, reads count
// - valid block size stored, multiple mode on
// - zero block size disables multiple mode
// - hard reset defaults multiple off; soft reset unless kept
// - sleep command: busy, sleep, clear, interrupt
// - any new command wakes from sleep
// - idle timer enters sleep after 5 ms
// - standby: busy, sleep, clear, interrupt
// - standby immediate: busy, sleep, clear, interrupt
// - buffer write moves exactly 512 bytes
// - dma write 1..256 sectors, zero means 256
// - dma write sets busy first, then request
// - dma_request held while data can be accepted
// - logical address from head, cylinder, sector fields
// - dma write accepts 512 bytes per sector
// - dma interrupt only at end or error
// - 8-bit mode enabled aborts dma write
`ifndef CARD_EXEC_DEFS_SVH
`define CARD_EXEC_DEFS_SVH

`define IDX_DATA      4'h0
`define IDX_FEATURE   4'h1
`define IDX_COUNT     4'h2
`define IDX_SECNUM    4'h3
`define IDX_CYL_LO    4'h4
`define IDX_CYL_HI    4'h5
`define IDX_HEAD      4'h6
`define IDX_COMMAND   4'h7
`define IDX_CONTROL   4'h8

`define CMD_VERIFY0   8'h40
`define CMD_VERIFY1   8'h41
`define CMD_FEATURE   8'hef
`define CMD_SETMULT   8'hc6
`define CMD_SLEEP0    8'he6
`define CMD_SLEEP1    8'h99
`define CMD_STBY0     8'he2
`define CMD_STBY1     8'h96
`define CMD_STBYI0    8'he0
`define CMD_STBYI1    8'h94
`define CMD_WRBUF     8'he8
`define CMD_DMAWR     8'hca

`define SUB_XFER_MODE 8'h03
`define SUB_NO_LOOKAH 8'h55
`define SUB_WC_ON     8'h02
`define SUB_WC_OFF    8'h82
`define SUB_KEEP      8'h66
`define SUB_REVERT    8'hcc
`define SUB_8BIT_ON   8'h01
`define SUB_8BIT_OFF  8'h81

`define ST_BUSY_BIT   7
`define ST_READY_BIT  6
`define ST_DRQ_BIT    3
`define ST_ERR_BIT    0
`define ER_UNC_BIT    6
`define ER_ABRT_BIT   2
`define HD_LBA_BIT    6
`define CTL_SRST_BIT  2

`define LAST_WORD     8'hff
`define CLK_MHZ       125
`define IDLE_TIME_US  5000
`define IDLE_CYCLES   (`IDLE_TIME_US * `CLK_MHZ)

`endif

/* rtl/card_exec_pkg.sv */
// types shared by the card command executor
// assumes nothing beyond a SystemVerilog compiler
package card_exec_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_exec,
      st_verify,
      st_pio_wr,
      st_dma_start,
      st_dma_xfer
   } exec_state_t;
endpackage

/* test/card_exec_assertions.sv */
// concurrent checks on the card command executor, bound to every instance
// assumes a zero-wait apb master and a host that strobes only under acknowledge
`timescale 1ns/1ns
`default_nettype none
module card_exec_checker (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        dma_acknowledge_n,
   input wire logic        io_write_strobe_n,
   input wire logic        dma_request,
   input wire logic        host_interrupt,
   input wire logic        sleep_mode,
   input wire logic        buf_wr_en
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   function automatic logic is_sleep(logic [7:0] c);
      return c inside {8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94};
   endfunction
   sequence cmd_wr;
      psel && penable && pwrite && paddr == 8'h1c;
   endsequence
   sequence sleep_wr;
      cmd_wr ##0 is_sleep(pwdata[7:0]);
   endsequence
   sequence wake_wr;
      cmd_wr ##0 (sleep_mode && !is_sleep(pwdata[7:0]));
   endsequence
   a_cmd_irq_clear: assert property (cmd_wr |=> !host_interrupt)
      else $error("interrupt survived a command write");
   a_sleep_entry: assert property (sleep_wr |-> ##[2:4] (host_interrupt && sleep_mode))
      else $error("sleep command did not end asleep with interrupt");
   a_sleep_wake: assert property (wake_wr |-> ##[1:3] !sleep_mode)
      else $error("new command did not wake the card");
   a_verify_no_dma: assert property (cmd_wr ##0 pwdata[7:1] == 7'h20 |=> !dma_request [*8])
      else $error("verify raised a data request");
   a_dma_start: assert property (cmd_wr ##0 pwdata[7:0] == 8'hca |-> ##[2:6] (dma_request || host_interrupt))
      else $error("dma write neither started nor aborted");
   a_dma_no_irq: assert property (dma_request |-> !host_interrupt)
      else $error("interrupt during dma transfer");
   a_dma_end_irq: assert property ($fell(dma_request) |-> ##[0:4] host_interrupt)
      else $error("no interrupt at end of dma");
   a_word_accept: assert property ($rose(io_write_strobe_n) && !dma_acknowledge_n && dma_request |-> ##[2:5] buf_wr_en)
      else $error("strobed word not written");
   a_word_single: assert property (buf_wr_en |=> !buf_wr_en)
      else $error("one word written twice");
   a_bad_addr: assert property (psel && penable && (paddr[1:0] != 2'b00 || paddr >= 8'h24) |-> pslverr)
      else $error("unmapped access without slave error");
endmodule
bind card_exec card_exec_checker chk_i (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pslverr, .dma_acknowledge_n, .io_write_strobe_n, .dma_request, .host_interrupt, .sleep_mode,
   .buf_wr_en);
`default_nettype wire

/* test/host_dma_model.sv */
// host side of the dma write handshake: acknowledge, write strobe, data pins
// assumes the card synchronises all three, so data stays put around the strobe rise
`timescale 1ns/1ns
`default_nettype none
module host_dma_model #(
   parameter logic [15:0] BASE = 16'h5a00
) (
   input  wire logic        clk_sys,
   input  wire logic        dma_request,
   input  wire logic        slow,
   output logic             dma_acknowledge_n,
   output logic             io_write_strobe_n,
   output logic      [15:0] host_data_in
);
   logic [2:0]  cnt = 3'd0;
   logic [15:0] word = BASE;
   initial begin
      dma_acknowledge_n = 1'b1;
      io_write_strobe_n = 1'b1;
      host_data_in = 16'h0;
   end
   always @(posedge clk_sys) begin
      if (cnt == 3'd0 && dma_request !== 1'b1) begin
         // released bus: data toggles so a stale word never looks valid
         dma_acknowledge_n <= 1'b1;
         io_write_strobe_n <= 1'b1;
         host_data_in      <= ~host_data_in;
         word              <= BASE;
      end else begin
         dma_acknowledge_n <= 1'b0;
         cnt <= cnt + 3'd1;
         if (cnt == 3'd0) host_data_in <= word;
         if (cnt == 3'd1) io_write_strobe_n <= 1'b0;
         if (cnt == (slow ? 3'd5 : 3'd3)) begin
            io_write_strobe_n <= 1'b1;
            word <= word + 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* test/ata_card_command_executor_test.sv */
// self-checking bench for card_exec: apb register tasks, host dma model at the far side
// assumes defines header and package compiled first; idle timer shortened to 50 cycles
`timescale 1ns/1ns
`default_nettype none
module ata_card_command_executor_test;
   logic        clk_sys, pready, pslverr, dma_acknowledge_n, io_write_strobe_n;
   logic        srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        verify_error = 1'b0, slow = 1'b0;
   logic        dma_request, host_interrupt, sleep_mode, buf_wr_en;
   logic [7:0]  paddr = 8'h0, buf_wr_addr;
   logic [15:0] host_data_in, buf_wr_data, base;
   logic [31:0] pwdata = 32'h0, prdata, v;
   logic        slverr_seen;
   int          err_total = 0, cmp_count = 0, cyc = 0, n = 0, i, k;
   logic [7:0]  fsub[8] = '{8'h03, 8'h55, 8'h02, 8'h82, 8'h66, 8'hcc, 8'h77, 8'h03};
   logic [7:0]  fcnt[8] = '{8'h08, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h10};
   logic [7:0]  mcnt[5] = '{8'h04, 8'h03, 8'h20, 8'h10, 8'h00};
   logic [7:0]  mblk[5] = '{8'h04, 8'h04, 8'h04, 8'h10, 8'h00};
   logic [7:0]  slp[6] = '{8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94};
   card_exec #(.IDLE_CYCLES(50), .VERIFY_CYCLES(4)) dut (.clk_sys, .srst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_data_in, .dma_acknowledge_n,
      .io_write_strobe_n, .verify_error, .dma_request, .host_interrupt, .sleep_mode, .buf_wr_en,
      .buf_wr_addr, .buf_wr_data);
   host_dma_model hd (.clk_sys, .dma_request, .slow, .dma_acknowledge_n, .io_write_strobe_n,
      .host_data_in);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      v = prdata;
      slverr_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, v, exp);
   endtask
   task automatic cmd(input logic [7:0] c);
      wr(8'h1c, {24'h0, c});
   endtask
   task automatic wait_irq();
      for (k = 0; k < 8000 && host_interrupt !== 1'b1; k++) @(posedge clk_sys);
      chk("interrupt", 32'(host_interrupt), 32'h1);
   endtask
   task automatic blk(input logic [7:0] exp);
      apb(1'b0, 8'h20, 32'h0);
      chk("block size", 32'(v[31:24]), 32'(exp));
   endtask
   task automatic feat(input logic [7:0] sub, input logic [7:0] cnt, input logic [31:0] st);
      wr(8'h04, 32'(sub));
      wr(8'h08, 32'(cnt));
      cmd(8'hef);
      wait_irq();
      rd(8'h1c, st, "feature status");
   endtask
   task automatic mult(input logic [7:0] cnt, input logic [31:0] st, input logic [7:0] b);
      wr(8'h08, 32'(cnt));
      cmd(8'hc6);
      wait_irq();
      rd(8'h1c, st, "block status");
      blk(b);
   endtask
   task automatic soft_reset();
      wr(8'h20, 32'h4);
      wr(8'h20, 32'h0);
   endtask
   task automatic hard_reset();
      srst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // every written word is checked in order against the expected stream
   always @(posedge clk_sys) if (buf_wr_en === 1'b1) begin
      chk("word index", 32'(buf_wr_addr), 32'(n[7:0]));
      chk("word data", 32'(buf_wr_data), 32'(base + n[15:0]));
      n++;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      hard_reset();
      rd(8'h1c, 32'h40, "status after reset");
      chk("no slave error", 32'(slverr_seen), 32'h0);
      blk(8'h0);
      rd(8'h24, 32'h0, "unmapped read");
      chk("slave error", 32'(slverr_seen), 32'h1);
      wr(8'h18, 32'h40);
      wr(8'h14, 32'h0);
      wr(8'h10, 32'h12);
      wr(8'h0c, 32'hff);
      wr(8'h08, 32'h2);
      cmd(8'h40);
      wait_irq();
      rd(8'h1c, 32'h40, "verify status");
      rd(8'h0c, 32'h00, "verified sector");
      rd(8'h10, 32'h13, "verified low track");
      verify_error <= 1'b1;
      wr(8'h0c, 32'h20);
      wr(8'h08, 32'h3);
      cmd(8'h41);
      wait_irq();
      rd(8'h1c, 32'h41, "verify fail status");
      rd(8'h04, 32'h40, "verify fail error");
      rd(8'h0c, 32'h20, "failing sector");
      rd(8'h08, 32'h3, "unverified count");
      verify_error <= 1'b0;
      for (i = 0; i < 8; i++) feat(fsub[i], fcnt[i], i < 6 ? 32'h40 : 32'h41);
      for (i = 0; i < 5; i++) mult(mcnt[i], (i == 1 || i == 2) ? 32'h41 : 32'h40, mblk[i]);
      mult(8'h04, 32'h40, 8'h04);
      soft_reset();
      blk(8'h0);
      feat(8'h66, 8'h0, 32'h40);
      mult(8'h04, 32'h40, 8'h04);
      soft_reset();
      blk(8'h04);
      hard_reset();
      blk(8'h0);
      for (i = 0; i < 6; i++) begin
         cmd(slp[i]);
         wait_irq();
         chk("asleep", 32'(sleep_mode), 32'h1);
         rd(8'h1c, 32'h40, "sleep status");
      end
      feat(8'h55, 8'h0, 32'h40);
      chk("awake", 32'(sleep_mode), 32'h0);
      repeat (30) @(posedge clk_sys);
      chk("not yet idle asleep", 32'(sleep_mode), 32'h0);
      for (k = 0; k < 60 && sleep_mode !== 1'b1; k++) @(posedge clk_sys);
      chk("idle asleep", 32'(sleep_mode), 32'h1);
      cmd(8'he8);
      for (k = 0; k < 20 && v[3] !== 1'b1; k++) apb(1'b0, 8'h1c, 32'h0);
      chk("buffer request status", v, 32'h48);
      base = 16'h1000;
      n = 0;
      for (i = 0; i < 256; i++) wr(8'h00, 32'h1000 + 32'(i));
      rd(8'h1c, 32'h40, "buffer done status");
      chk("buffer words", n, 32'd256);
      wr(8'h18, 32'h40);
      for (i = 0; i < 2; i++) begin
         slow <= i[0];
         wr(8'h0c, 32'h5);
         wr(8'h08, 32'(i + 1));
         base = 16'h5a00;
         n = 0;
         cmd(8'hca);
         wait_irq();
         // last word is counted on the edge the interrupt is seen
         @(posedge clk_sys);
         chk("dma words", n, 32'(256 * (i + 1)));
         chk("dma request off", 32'(dma_request), 32'h0);
         rd(8'h1c, 32'h40, "dma status");
         rd(8'h0c, 32'(5 + i), "dma last sector");
      end
      feat(8'h01, 8'h0, 32'h40);
      cmd(8'hca);
      wait_irq();
      chk("no dma in 8-bit", 32'(dma_request), 32'h0);
      rd(8'h1c, 32'h41, "8-bit dma status");
      rd(8'h04, 32'h04, "8-bit dma error");
      feat(8'h81, 8'h0, 32'h40);
      final_report();
   end
endmodule
`default_nettype wire
